// ---- bench/card_model.sv ----
// Behavioural card on one command line: frame capture and reply
`timescale 1ns/1ps
module card_model (
  // Card pins
  input wire logic clk_pin,
  input wire logic line,
  // Scenario control
  input wire logic answer,
  input wire logic [7:0] rsp_len,
  input wire logic [135:0] rsp_bits,
  // Pull-down request and captured frame
  output logic drv_low,
  output logic [47:0] frame
);
  // ****
  // Card behaviour
  // ****
  int cnt = 0;
  int gap = 0;
  int tx = 0;
  logic busy = 1'h0;
  initial drv_low = 1'h0;
  initial frame = '0;
  // Host bits sampled mid-cell, on the falling edge
  always @(negedge clk_pin) begin
    if (!busy && (cnt > 0 || line === 1'h0)) begin
      frame <= {frame[46:0], line};
      cnt <= (cnt == 47) ? 0 : cnt + 1;
      if (cnt == 47) begin
        busy <= answer; // A silent card lets the host time out
        gap <= 2;
        tx <= rsp_len;
      end
    end
  end
  // Reply bits change on the rising edge, then the line is let go
  always @(posedge clk_pin) begin
    if (busy && gap > 0) begin
      gap <= gap - 1;
    end else if (busy && tx > 0) begin
      drv_low <= !rsp_bits[tx-1]; // Ones are left to the pull-up
      tx <= tx - 1;
    end else begin
      drv_low <= 1'h0;
      busy <= 1'h0;
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench: register bus, command link, clock control
`timescale 1ns/1ps
module tb_top;
  // ****
  // Signals
  // ****
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] irq = 2'h2; // Slot 1 card raises its interrupt line
  logic rxf = '0, txf = '0, bend = '0, ans = '1, od = '0, s1 = '0;
  logic awready, wready, bvalid, arready, rvalid, cclk, low;
  logic [1:0] bresp, rresp, c_out, c_oe, c_in;
  logic [31:0] rdata, got, seed = 32'hBAF9;
  logic [3:0] lanes;
  logic [47:0] frame;
  logic [135:0] rsp = '0;
  logic [7:0] rlen = 8'h30;
  logic [34:0] q[$];
  int error_cnt = 0, cmp_count = 0, cyc = 0, n0, n1;

  card_host dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .card_clock_pin(cclk), .command_line_out(c_out), .command_line_oe(c_oe),
    .command_line_in(c_in), .card_irq_line(irq), .data_lane_en(lanes),
    .rx_fifo_full(rxf), .tx_fifo_full(txf), .block_end(bend)
  );
  card_model card (.clk_pin(cclk), .line(c_in[0]), .answer(ans), .rsp_len(rlen),
    .rsp_bits(rsp), .drv_low(low), .frame(frame));

  // Clock, pulled-up command lines, hang limit
  always #12.5 aclk = ~aclk;
  assign c_in = {!(c_oe[1] && !c_out[1]), !((c_oe[0] && !c_out[0]) || low)};
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      conclude();
    end
  end

  // ****
  // Helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [6:0] crc7(input logic [39:0] m);
    logic [6:0] c;
    logic b;
    c = '0;
    for (int i = 39; i >= 0; i--) begin
      b = m[i] ^ c[6];
      c = {c[5:0], 1'h0} ^ (b ? 7'h09 : 7'h00);
    end
    return c;
  endfunction
  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    cmp_count++;
    if (e !== g) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Oldest note is matched when a response handshake lands
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      if (q.size() == 0) chk("note", '0, '1);
      else if (!q[0][34]) chk("resp", q[0], {1'h0, rvalid ? {rresp, rdata} : {bresp, 32'h0}});
      if (q.size() > 0) void'(q.pop_front());
    end
    if (od && c_oe[0] && c_out[0]) chk("opendrain", '0, '1);
    if (s1 && c_oe[0]) chk("slot", '0, '1);
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    q.push_back({1'h0, e, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= '1;
    wvalid <= '1;
    bready <= '1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= '0;
      if (wready) wvalid <= '0;
    end while (!bvalid);
    bready <= '0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [34:0] e);
    q.push_back(e);
    araddr <= a;
    arvalid <= '1;
    rready <= '1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= '0;
    end while (!rvalid);
    got = rdata;
    rready <= '0;
    @(posedge aclk);
  endtask
  task automatic st(input logic [7:0] e);
    rd(card_host_pkg::OFF_STATUS, {27'h0, e});
  endtask
  task automatic cmd(input logic [5:0] x, input logic [31:0] arg, input logic [31:0] f);
    int n;
    n = 0;
    wr(card_host_pkg::OFF_ARGUMENT, arg);
    wr(card_host_pkg::OFF_COMMAND, f | x);
    do begin
      rd(card_host_pkg::OFF_STATUS, {1'h1, 34'h0});
      n++;
    end while (!got[0] && n < 400);
    chk("done", 1'h1, got[0]);
    if (!s1) chk("frame", {2'h1, x, arg, crc7({2'h1, x, arg}), 1'h1}, frame);
  endtask
  task automatic pulse;
    bend <= '1;
    @(posedge aclk);
    bend <= '0;
  endtask
  task automatic tog(output int n);
    logic p;
    n = 0;
    p = cclk;
    repeat (80) begin
      @(posedge aclk);
      if (cclk !== p) n++;
      p = cclk;
    end
  endtask

  // ****
  // Scenarios
  // ****
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= '1;
    @(posedge aclk);
    chk("clk", '0, cclk);
    chk("lanes", '0, lanes);
    wr(card_host_pkg::OFF_COMMAND, 32'h40);
    repeat (20) @(posedge aclk);
    chk("oe", '0, c_oe);
    st(8'h01);
    rd(8'h1C, {1'h0, card_host_pkg::RESP_SLVERR, 32'h0});
    wr(8'h1C, 32'h1, card_host_pkg::RESP_SLVERR);
    wr(card_host_pkg::OFF_MODE, 32'h1001); // Half period two cycles, read stall on
    wr(card_host_pkg::OFF_CONTROL, 32'h1);
    wr(card_host_pkg::OFF_CARD_CFG, 32'h2);
    chk("wide", 4'hF, lanes);
    wr(card_host_pkg::OFF_CARD_CFG, 32'h0);
    chk("narrow", 4'h1, lanes);
    // Idle clock must slow down under power save
    tog(n0);
    wr(card_host_pkg::OFF_MODE, 32'h1901);
    tog(n1);
    chk("pwsave", 1'h1, n1 < n0 && n1 > 0);
    wr(card_host_pkg::OFF_MODE, 32'h1001);
    // Identification: long reply, open drain
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      rsp[32*i +: 32] = seed;
    end
    rsp[135:128] = 8'h3F;
    rlen = 8'h88;
    od <= '1;
    cmd(6'h02, seed, 32'h0880);
    od <= '0;
    for (int i = 0; i < 4; i++) begin
      rd(card_host_pkg::OFF_RESP0 + 8'(4*i), {3'h0, rsp[32*i +: 32]});
    end
    st(8'h11);
    // Direction and type without the transfer flag start nothing
    rlen = 8'h30;
    seed = lfsr(seed);
    rsp[47:0] = {2'h0, 6'h11, seed, 8'h01};
    cmd(6'h0D, seed, 32'h0014_0040);
    st(8'h11);
    // Single block read: stall freezes the clock, block end closes it
    cmd(6'h11, seed, 32'h0005_0040);
    st(8'h15);
    rxf <= '1;
    repeat (4) @(posedge aclk);
    tog(n0);
    chk("stall", '0, n0);
    rxf <= '0;
    pulse();
    st(8'h11);
    // Stream runs until a stop command
    cmd(6'h14, seed, 32'h0011_0040);
    pulse();
    st(8'h15);
    // Write stall parks the clock during the outgoing stream
    wr(card_host_pkg::OFF_MODE, 32'h2001);
    txf <= '1;
    repeat (4) @(posedge aclk);
    tog(n0);
    chk("wstall", '0, n0);
    txf <= '0;
    wr(card_host_pkg::OFF_MODE, 32'h1001);
    cmd(6'h0C, seed, 32'h0002_0040);
    st(8'h11);
    // Multi block with a count of two
    wr(card_host_pkg::OFF_BLOCK, 32'h2);
    cmd(6'h12, seed, 32'h0009_0040);
    pulse();
    st(8'h15);
    pulse();
    st(8'h11);
    // Slot 1 alone carries the command
    wr(card_host_pkg::OFF_CARD_CFG, 32'h1);
    s1 <= '1;
    cmd(6'h00, 32'h0, 32'h0);
    st(8'h31);
    s1 <= '0;
    wr(card_host_pkg::OFF_CARD_CFG, 32'h0);
    // Silent card: timeout after the latency window
    ans <= '0;
    cmd(6'h05, seed, 32'h0040);
    st(8'h13);
    // Long latency window still ends in a timeout
    cmd(6'h06, seed, 32'h1040);
    st(8'h13);
    conclude();
  end
endmodule

// ---- common/card_host_pkg.sv ----
// Constants, register map and field layout of the memory card host block
//
// Summary of operation
// - SD bus: one line or four per width bit
// - MultiMedia cards use data line 0 only
// - Disabled after reset until enable bit set
// - Idle power save slows card clock further
// - Stall protection stops clock while FIFO full
// - Command and response bits change on rising edge
// - Command line open-drain or push-pull per command
// - Latency field zero waits five card clocks
// - Response type two captures 136-bit response
// - Direction and type ignored without transfer flag
// - Serial command line, data lines, card clock
// - Stream transfer ends only on stop command
// - Each data block followed by its CRC
// - Multi-block ends on stop or count exhausted
// - Addressed operation is command then response
// - Command done flag set after completed command
// - One of two slots active, chosen by slot
package card_host_pkg;
  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CARD_CFG = 8'h08;
  localparam logic [7:0] OFF_BLOCK = 8'h0C;
  localparam logic [7:0] OFF_ARGUMENT = 8'h10;
  localparam logic [7:0] OFF_COMMAND = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_RESP0 = 8'h20;
  localparam logic [7:0] OFF_RESP3 = 8'h2C;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTL_ENABLE = 0;
  localparam int CTL_DISABLE = 1;
  localparam int MODE_PSDIV_LO = 8;
  localparam int MODE_PSE = 11;
  localparam int MODE_RDSTALL = 12;
  localparam int MODE_WRSTALL = 13;
  localparam int CFG_SLOT = 0;
  localparam int CFG_WIDTH = 1;
  localparam int CMD_RSP_LO = 6;
  localparam int CMD_OPEN_DRAIN = 11;
  localparam int CMD_MAX_LATENCY_FIELD = 12;
  localparam int CMD_TR_LO = 16;
  localparam int CMD_DIR = 18;
  localparam int CMD_TYP_LO = 19;
  localparam logic [31:0] CMD_MASK = 32'h031F1FFF;
  // ****************************************
  // Encodings and counts
  // ****************************************
  localparam logic [1:0] RSP_NONE = 2'h0;
  localparam logic [1:0] RSP_LONG = 2'h2;
  localparam logic [1:0] TR_START = 2'h1;
  localparam logic [1:0] TR_STOP = 2'h2;
  localparam logic [1:0] TYP_SINGLE = 2'h0;
  localparam logic [1:0] TYP_MULTI = 2'h1;
  localparam logic [7:0] FRAME_BITS = 8'h30;
  localparam logic [7:0] SHORT_BITS = 8'h30;
  localparam logic [7:0] LONG_BITS = 8'h88;
  localparam logic [6:0] LAT_SHORT = 7'h05;
  localparam logic [6:0] LAT_LONG = 7'h40;
  localparam logic [6:0] CRC7_POLY = 7'h09;
  localparam logic [7:0] CLKDIV_RESET = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SEND = 4'h2,
    ST_WAIT = 4'h4,
    ST_RECV = 4'h8
  } cmd_state_e;
endpackage

// ---- rtl/card_host.sv ----
// Memory card host: AXI4-Lite registers, card clock, command and response engine
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module card_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Card pins, slot 0 and slot 1 share the clock
  output logic card_clock_pin,
  output logic [1:0] command_line_out,
  output logic [1:0] command_line_oe,
  input wire logic [1:0] command_line_in,
  input wire logic [1:0] card_irq_line,
  output logic [3:0] data_lane_en,
  // Data path handshake
  input wire logic rx_fifo_full,
  input wire logic tx_fifo_full,
  input wire logic block_end
);
  typedef card_host_pkg::cmd_state_e cmd_state_t;
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic en;
    logic [13:0] mode;
    logic [1:0] cfg;
    logic [15:0] blk_total;
    logic [31:0] arg;
    logic [31:0] cmd;
    logic done;
    logic tmo;
    logic xfer;
    logic xdir;
    logic [1:0] xtyp;
    logic [15:0] blk_seen;
    cmd_state_t state;
    logic [47:0] frame;
    logic [7:0] bitc;
    logic [6:0] latc;
    logic [127:0] rsp;
    logic [7:0] div;
    logic [7:0] ps;
    logic cclk;
    logic [1:0] cmdo;
    logic [1:0] cmdoe;
    logic [3:0] lanes;
  } state_s;

  state_s st_q;
  state_s st_d;

  // Byte-lane merge for AXI write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // CRC7 over start, transmission, index and argument bits of a command token
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ card_host_pkg::CRC7_POLY;
      end
    end
    return c;
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  logic do_write;
  logic [31:0] wv;
  logic launch;
  logic stall;
  logic saving;
  logic tick;
  logic rise;
  logic fall;
  logic [7:0] ps_lim;
  logic [7:0] rsp_len;
  logic [6:0] lat_lim;
  logic [39:0] head;
  logic rsp_in;
  logic complete;
  logic xfer_end;

  always_comb begin
    st_d = st_q;
    complete = 1'b0;
    xfer_end = 1'b0;
    wv = 32'h0000_0000;
    launch = 1'b0;
    // Write: address and data taken in either order, answered once both are in
    if (st_q.awready && awvalid) begin
      st_d.aw_held = 1'b1;
      st_d.aw_addr = awaddr;
    end
    if (st_q.wready && wvalid) begin
      st_d.w_held = 1'b1;
      st_d.w_data = wdata;
      st_d.w_strb = wstrb;
    end
    do_write = st_q.aw_held && st_q.w_held && !st_q.bvalid;
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    if (do_write) begin
      st_d.aw_held = 1'b0;
      st_d.w_held = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = card_host_pkg::RESP_OKAY;
      if (st_q.aw_addr == card_host_pkg::OFF_CONTROL) begin
        wv = merge(32'h0000_0000, st_q.w_data, st_q.w_strb);
        if (wv[card_host_pkg::CTL_DISABLE]) begin
          st_d.en = 1'b0;
        end else if (wv[card_host_pkg::CTL_ENABLE]) begin
          st_d.en = 1'b1;
        end
      end else if (st_q.aw_addr == card_host_pkg::OFF_MODE) begin
        wv = merge({18'h00000, st_q.mode}, st_q.w_data, st_q.w_strb);
        st_d.mode = wv[13:0];
      end else if (st_q.aw_addr == card_host_pkg::OFF_CARD_CFG) begin
        wv = merge({30'h0000_0000, st_q.cfg}, st_q.w_data, st_q.w_strb);
        st_d.cfg = wv[1:0];
      end else if (st_q.aw_addr == card_host_pkg::OFF_BLOCK) begin
        wv = merge({16'h0000, st_q.blk_total}, st_q.w_data, st_q.w_strb);
        st_d.blk_total = wv[15:0];
      end else if (st_q.aw_addr == card_host_pkg::OFF_ARGUMENT) begin
        st_d.arg = merge(st_q.arg, st_q.w_data, st_q.w_strb);
      end else if (st_q.aw_addr == card_host_pkg::OFF_COMMAND) begin
        // Ignored while disabled or while a command is still under way
        launch = st_q.en && (st_q.state == card_host_pkg::ST_IDLE);
        if (launch) begin
          st_d.cmd = merge(st_q.cmd, st_q.w_data, st_q.w_strb) & card_host_pkg::CMD_MASK;
        end
      end else if (st_q.aw_addr != card_host_pkg::OFF_STATUS
                   && !(st_q.aw_addr >= card_host_pkg::OFF_RESP0
                        && st_q.aw_addr <= card_host_pkg::OFF_RESP3)) begin
        st_d.bresp = card_host_pkg::RESP_SLVERR;
      end
    end
    st_d.awready = !st_d.aw_held && !st_d.bvalid;
    st_d.wready = !st_d.w_held && !st_d.bvalid;
    // Read: one cycle from address to data
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    if (st_q.arready && arvalid) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = card_host_pkg::RESP_OKAY;
      if (araddr == card_host_pkg::OFF_CONTROL) begin
        st_d.rdata = 32'h0000_0000;
      end else if (araddr == card_host_pkg::OFF_MODE) begin
        st_d.rdata = {18'h00000, st_q.mode};
      end else if (araddr == card_host_pkg::OFF_CARD_CFG) begin
        st_d.rdata = {30'h0000_0000, st_q.cfg};
      end else if (araddr == card_host_pkg::OFF_BLOCK) begin
        st_d.rdata = {16'h0000, st_q.blk_total};
      end else if (araddr == card_host_pkg::OFF_ARGUMENT) begin
        st_d.rdata = st_q.arg;
      end else if (araddr == card_host_pkg::OFF_COMMAND) begin
        st_d.rdata = st_q.cmd;
      end else if (araddr == card_host_pkg::OFF_STATUS) begin
        st_d.rdata = {26'h0000000, card_irq_line[st_q.cfg[card_host_pkg::CFG_SLOT]], st_q.en,
                      (st_q.state != card_host_pkg::ST_IDLE), st_q.xfer, st_q.tmo, st_q.done};
      end else if (araddr >= card_host_pkg::OFF_RESP0 && araddr <= card_host_pkg::OFF_RESP3) begin
        st_d.rdata = st_q.rsp[araddr[3:2]*32 +: 32];
      end else begin
        st_d.rdata = 32'h0000_0000;
        st_d.rresp = card_host_pkg::RESP_SLVERR;
      end
    end
    st_d.arready = !st_d.rvalid;

    // Card clock: half period of (div+1) cycles, stretched while idle in power save
    stall = st_q.xfer && (st_q.xdir ? (st_q.mode[card_host_pkg::MODE_RDSTALL] && rx_fifo_full)
                                     : (st_q.mode[card_host_pkg::MODE_WRSTALL] && tx_fifo_full));
    saving = st_q.mode[card_host_pkg::MODE_PSE] && !st_q.xfer
             && (st_q.state == card_host_pkg::ST_IDLE);
    ps_lim = saving ? ((8'h01 << st_q.mode[card_host_pkg::MODE_PSDIV_LO +: 3])) : 8'h00;
    tick = 1'b0;
    if (!st_q.en) begin
      st_d.div = 8'h00;
      st_d.ps = 8'h00;
    end else if (stall && !st_q.cclk) begin
      st_d.div = st_q.div; // Clock parked low, no data lost
    end else if (st_q.div >= st_q.mode[7:0]) begin
      st_d.div = 8'h00;
      if (st_q.ps >= ps_lim) begin
        st_d.ps = 8'h00;
        tick = 1'b1;
      end else begin
        st_d.ps = st_q.ps + 8'h01;
      end
    end else begin
      st_d.div = st_q.div + 8'h01;
    end
    rise = tick && !st_q.cclk;
    fall = tick && st_q.cclk;
    st_d.cclk = st_q.en && (tick ? !st_q.cclk : st_q.cclk);

    // Command engine
    rsp_len = (st_q.cmd[card_host_pkg::CMD_RSP_LO +: 2] == card_host_pkg::RSP_LONG)
              ? card_host_pkg::LONG_BITS : card_host_pkg::SHORT_BITS;
    lat_lim = st_q.cmd[card_host_pkg::CMD_MAX_LATENCY_FIELD] ? card_host_pkg::LAT_LONG
                                                  : card_host_pkg::LAT_SHORT;
    rsp_in = command_line_in[st_q.cfg[card_host_pkg::CFG_SLOT]];
    head = 40'h00_0000_0000;
    case (st_q.state)
      card_host_pkg::ST_IDLE: begin
        if (launch) begin
          head = {2'h1, st_d.cmd[5:0], st_q.arg};
          st_d.frame = {head, crc7(head), 1'b1};
          st_d.bitc = 8'h00;
          st_d.latc = 7'h00;
          st_d.done = 1'b0;
          st_d.tmo = 1'b0;
          st_d.state = card_host_pkg::ST_SEND;
        end
      end
      card_host_pkg::ST_SEND: begin
        if (rise) begin
          if (st_q.bitc == card_host_pkg::FRAME_BITS) begin
            st_d.cmdoe = 2'h0;
            if (st_q.cmd[card_host_pkg::CMD_RSP_LO +: 2] == card_host_pkg::RSP_NONE) begin
              complete = 1'b1;
            end else begin
              st_d.state = card_host_pkg::ST_WAIT;
            end
          end else begin
            st_d.frame = {st_q.frame[46:0], 1'b0};
            st_d.bitc = st_q.bitc + 8'h01;
            st_d.cmdo = 2'h0;
            st_d.cmdoe = 2'h0;
            if (st_q.cmd[card_host_pkg::CMD_OPEN_DRAIN]) begin
              // Open drain: only pull low, release for a one
              st_d.cmdoe[st_q.cfg[card_host_pkg::CFG_SLOT]] = !st_q.frame[47];
            end else begin
              st_d.cmdo[st_q.cfg[card_host_pkg::CFG_SLOT]] = st_q.frame[47];
              st_d.cmdoe[st_q.cfg[card_host_pkg::CFG_SLOT]] = 1'b1;
            end
          end
        end
      end
      card_host_pkg::ST_WAIT: begin
        // Card drives on its rising edge, so sample on our falling edge
        if (fall) begin
          if (!rsp_in) begin
            st_d.bitc = 8'h01;
            st_d.rsp = {st_q.rsp[126:0], rsp_in};
            st_d.state = card_host_pkg::ST_RECV;
          end else begin
            st_d.latc = st_q.latc + 7'h01;
            if (st_q.latc + 7'h01 == lat_lim) begin
              st_d.tmo = 1'b1;
              complete = 1'b1;
            end
          end
        end
      end
      card_host_pkg::ST_RECV: begin
        if (fall) begin
          st_d.rsp = {st_q.rsp[126:0], rsp_in};
          st_d.bitc = st_q.bitc + 8'h01;
          if (st_q.bitc + 8'h01 == rsp_len) begin
            complete = 1'b1;
          end
        end
      end
      default: begin
        st_d.state = card_host_pkg::ST_IDLE;
      end
    endcase
    if (complete) begin
      st_d.done = 1'b1;
      st_d.state = card_host_pkg::ST_IDLE;
      if (st_q.cmd[card_host_pkg::CMD_TR_LO +: 2] == card_host_pkg::TR_STOP) begin
        xfer_end = 1'b1;
      end else if (st_q.cmd[card_host_pkg::CMD_TR_LO +: 2] == card_host_pkg::TR_START
                   && !st_q.tmo && !st_d.tmo) begin
        // Direction and type only matter for a transfer command
        st_d.xfer = 1'b1;
        st_d.xdir = st_q.cmd[card_host_pkg::CMD_DIR];
        st_d.xtyp = st_q.cmd[card_host_pkg::CMD_TYP_LO +: 2];
        st_d.blk_seen = 16'h0000;
      end
    end
    // Block end pulse follows each block and its CRC
    if (st_q.xfer && block_end) begin
      st_d.blk_seen = st_q.blk_seen + 16'h0001;
      if (st_q.xtyp == card_host_pkg::TYP_SINGLE
          || (st_q.xtyp == card_host_pkg::TYP_MULTI && st_q.blk_total != 16'h0000
              && st_q.blk_seen + 16'h0001 == st_q.blk_total)) begin
        xfer_end = 1'b1;
      end
    end
    if (xfer_end) begin
      st_d.xfer = 1'b0;
    end
    // Lanes: none while disabled, four with wide bus, else line 0 only and 1..3 released
    st_d.lanes = !st_q.en ? 4'h0 : (st_q.cfg[card_host_pkg::CFG_WIDTH] ? 4'hF : 4'h1);
    if (!st_q.en) begin
      st_d.state = card_host_pkg::ST_IDLE;
      st_d.cmdoe = 2'h0;
      st_d.xfer = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.state <= card_host_pkg::ST_IDLE;
      st_q.mode <= {6'h00, card_host_pkg::CLKDIV_RESET};
      st_q.done <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign awready = st_q.awready;
  assign wready = st_q.wready;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = st_q.arready;
  assign rvalid = st_q.rvalid;
  assign rdata = st_q.rdata;
  assign rresp = st_q.rresp;
  assign card_clock_pin = st_q.cclk;
  assign command_line_out = st_q.cmdo;
  assign command_line_oe = st_q.cmdoe;
  assign data_lane_en = st_q.lanes;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_launch;
    st_q.state == card_host_pkg::ST_IDLE ##1 st_q.state == card_host_pkg::ST_SEND;
  endsequence

  a_disabled_clock: assert property (@(posedge aclk) disable iff (!aresetn)
    !st_q.en |=> !card_clock_pin) else $error("card clock runs while disabled");
  a_lane_width: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.en && $stable(st_q.cfg)
    |=> data_lane_en == ($past(st_q.cfg[card_host_pkg::CFG_WIDTH]) ? 4'hF : 4'h1))
    else $error("data lane set does not follow bus width");
  a_stall_parks: assert property (@(posedge aclk) disable iff (!aresetn)
    stall && !card_clock_pin |=> !card_clock_pin) else $error("card clock rose during stall");
  a_cmd_on_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(command_line_out) |-> $rose(card_clock_pin))
    else $error("command bit changed off the rising card edge");
  a_open_drain: assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.cmd[card_host_pkg::CMD_OPEN_DRAIN] && command_line_oe != 2'h0
    |-> command_line_out == 2'h0)
    else $error("open drain command drove a one");
  a_latency_five: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q.tmo) && !st_q.cmd[card_host_pkg::CMD_MAX_LATENCY_FIELD] |-> st_q.latc == 7'h05)
    else $error("response timeout not after five card clocks");
  a_long_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q.done) && !st_q.tmo && st_q.cmd[7:6] == card_host_pkg::RSP_LONG
    |-> st_q.bitc == card_host_pkg::LONG_BITS) else $error("long response not 136 bits");
  a_done_source: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_q.done) |-> $past(st_q.state) != card_host_pkg::ST_IDLE)
    else $error("done flag set with no command under way");
  a_slot_only: assert property (@(posedge aclk) disable iff (!aresetn)
    command_line_oe[!st_q.cfg[0]] == 1'b0) else $error("unselected slot driven");
  a_frame_head: assert property (@(posedge aclk) disable iff (!aresetn)
    s_launch |-> st_q.frame[47:46] == 2'h1 && st_q.frame[0]) else $error("bad command framing");
endmodule
